/* File: src/sss_cfg.svh */
`ifndef SSS_CFG_SVH
`define SSS_CFG_SVH

// register byte addresses, as carried in the low five bits of the command byte
`define SSS_ADDR_SILICON_STEP_CODE      5'h11
`define SSS_ADDR_PART_CODE              5'h12
`define SSS_ADDR_SENSOR_STATUS          5'h13
`define SSS_ADDR_LIGHT_CH0_LOW          5'h14
`define SSS_ADDR_LIGHT_CH0_HIGH         5'h15
`define SSS_ADDR_LIGHT_CH1_LOW          5'h16
`define SSS_ADDR_LIGHT_CH1_HIGH         5'h17
`define SSS_ADDR_PROXIMITY_RESULT_LOW   5'h18
`define SSS_ADDR_PROXIMITY_RESULT_HIGH  5'h19
`define SSS_ADDR_RST                    5'h00

// status byte field positions
`define SSS_ST_PROXIMITY_IRQ_FLAG       5
`define SSS_ST_LIGHT_IRQ_FLAG           4
`define SSS_ST_PROXIMITY_RESULT_READY   1
`define SSS_ST_LIGHT_RESULT_READY       0

// command byte layout
`define SSS_CMD_ADDR_MSB                4
`define SSS_CMD_TYPE_MSB                6
`define SSS_CMD_TYPE_LSB                5
`define SSS_CMD_TYPE_AUTO_INC           2'h1

// serial byte framing
`define SSS_BITS_PER_BYTE               4'h8
`define SSS_BIT_FIRST_SENT              4'h1
`define SSS_BYTE_MSB                    7
`define SSS_ADDR_STEP                   5'h01
`define SSS_RESULT_COUNT                3

`endif

/* File: src/sss_pkg.sv */
package sss_pkg;

  // serial slave sequencer states
  typedef enum logic [2:0] {
    SSS_IDLE     = 3'b000,
    SSS_ADDR     = 3'b001,
    SSS_ACK_ADDR = 3'b010,
    SSS_CMD      = 3'b011,
    SSS_ACK_BYTE = 3'b100,
    SSS_WDATA    = 3'b101,
    SSS_RDATA    = 3'b110,
    SSS_RACK     = 3'b111
  } sss_state_t;

  // whole state of the readout block
  typedef struct packed {
    sss_state_t       state;
    logic [7:0]       sh;
    logic [3:0]       cnt;
    logic             rw;
    logic             autoinc;
    logic             acked;
    logic [4:0]       ptr;
    logic [7:0]       tx;
    logic             oe;
    logic             scl_q;
    logic             sda_q;
    logic             prox_irq;
    logic             light_irq;
    logic             prox_ready;
    logic             light_ready;
    logic             irq;
    logic [2:0][7:0]  shadow;
  } sss_core_t;

endpackage : sss_pkg

/* File: src/sss_pin_sync.sv */
`timescale 1ns/1ps
module sss_pin_sync #(
  parameter int W = 2
) (
  input  wire logic         i_core_clk,
  input  wire logic         i_rst_n,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);

  if (W < 1) begin : g_bad_width
    $error("sss_pin_sync needs at least one bit");
  end

  typedef struct packed {
    logic [W-1:0] f1;
    logic [W-1:0] f2;
    logic [W-1:0] f3;
    logic [W-1:0] out;
  } sss_sync_t;

  sss_sync_t q;
  sss_sync_t d;

  // f1 feeds f2 only; a bit moves once f2 and f3 agree, so a one-sample glitch is dropped
  always_comb begin
    d     = q;
    d.f1  = i_async;
    d.f2  = q.f1;
    d.f3  = q.f2;
    d.out = (q.f2 & q.f3) | (q.out & (q.f2 ^ q.f3));
  end

  // bus idles high, so the chain starts high
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      q <= '1;
    end else begin
      q <= d;
    end
  end

  assign o_sync = q.out;

endmodule : sss_pin_sync

/* File: src/sss_readout.sv */
// What this block does
// [R1] The silicon step code register reads back a fixed byte that never changes.
// [R2] The part code register reads back a fixed 8-bit code naming the product variant.
// [R3] The status register is read-only and host writes leave its flags untouched.
// [R4] Status bit 5 reads one while the proximity interrupt is asserted.
// [R5] Status bit 4 reads one while the ambient light interrupt is asserted.
// [R6] Status bit 1 sets once a proximity integration cycle has finished.
// [R7] Status bit 0 sets once both light channels have finished an integration cycle.
// [R8] The host writes zeros into the reserved status bits 7:6 and 3:2.
// [R9] Light channel 0 sits as low and high bytes at 0x14/0x15, channel 1 at 0x16/0x17.
// [R10] The proximity result sits with its low byte at 0x18 and high byte at 0x19.
// [R11] Reading a low result byte copies its high byte into a shadow that the high read returns.
// [R12] The shadowed high byte stays matched to the low byte despite later integrations.
// [R13] The host fetches each result as one two-byte read with auto-increment selected.
// [R14] The ambient light interrupt comes from channel 0 results only.
// [R15] Interrupt flags hold until a clear command; the interrupt output releases once both flags are clear.
`timescale 1ns/1ps
`include "sss_cfg.svh"
module sss_readout #(
  parameter logic [6:0] SLAVE_ADDR = 7'h39,
  parameter logic [7:0] STEP_CODE  = 8'hA5,  // arbitrary value
  parameter logic [7:0] PART_CODE  = 8'h5A   // arbitrary value
) (
  input  wire logic        i_core_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_scl,
  input  wire logic        i_sda,
  output logic             o_sda,
  output logic             o_sda_oe,
  input  wire logic [15:0] i_ch0_data,
  input  wire logic [15:0] i_ch1_data,
  input  wire logic [15:0] i_prox_data,
  input  wire logic        i_light_done,
  input  wire logic        i_prox_done,
  input  wire logic        i_ch0_irq_set,
  input  wire logic        i_prox_irq_set,
  input  wire logic        i_light_irq_clr,
  input  wire logic        i_prox_irq_clr,
  output logic             o_sensor_irq
);

  if (SLAVE_ADDR == 7'h00) begin : g_bad_addr
    $error("general call address cannot be the slave address");
  end

  sss_pkg::sss_core_t q;
  sss_pkg::sss_core_t d;
  logic [1:0]         pins_s;
  logic               s_scl;
  logic               s_sda;
  logic               scl_rise;
  logic               scl_fall;
  logic               start_seen;
  logic               stop_seen;
  logic               ld;
  logic [7:0]         rd_byte;
  logic [7:0]         status_byte;
  logic [2:0][7:0]    live_high;

  // both bus pins come from the host's domain
  sss_pin_sync #(
    .W (2)
  ) u_pin_sync (
    .i_core_clk (i_core_clk),
    .i_rst_n    (i_rst_n),
    .i_async    ({i_scl, i_sda}),
    .o_sync     (pins_s)
  );

  assign s_scl      = pins_s[1];
  assign s_sda      = pins_s[0];
  assign scl_rise   = s_scl & ~q.scl_q;
  assign scl_fall   = ~s_scl & q.scl_q;
  assign start_seen = s_scl & q.scl_q & q.sda_q & ~s_sda;
  assign stop_seen  = s_scl & q.scl_q & ~q.sda_q & s_sda;
  assign live_high  = {i_prox_data[15:8], i_ch1_data[15:8], i_ch0_data[15:8]};

  // reserved status bits read as zero
  always_comb begin
    status_byte = 8'h00;
    status_byte[`SSS_ST_PROXIMITY_IRQ_FLAG]     = q.prox_irq;     // R4
    status_byte[`SSS_ST_LIGHT_IRQ_FLAG]         = q.light_irq;    // R5
    status_byte[`SSS_ST_PROXIMITY_RESULT_READY] = q.prox_ready;   // R6
    status_byte[`SSS_ST_LIGHT_RESULT_READY]     = q.light_ready;  // R7
  end

  // read map; high bytes come from the shadow, never live
  always_comb begin
    unique case (q.ptr)
      `SSS_ADDR_SILICON_STEP_CODE:     rd_byte = STEP_CODE;         // R1
      `SSS_ADDR_PART_CODE:             rd_byte = PART_CODE;         // R2
      `SSS_ADDR_SENSOR_STATUS:         rd_byte = status_byte;       // R3
      `SSS_ADDR_LIGHT_CH0_LOW:         rd_byte = i_ch0_data[7:0];   // R9
      `SSS_ADDR_LIGHT_CH0_HIGH:        rd_byte = q.shadow[0];       // R9
      `SSS_ADDR_LIGHT_CH1_LOW:         rd_byte = i_ch1_data[7:0];   // R9
      `SSS_ADDR_LIGHT_CH1_HIGH:        rd_byte = q.shadow[1];       // R9
      `SSS_ADDR_PROXIMITY_RESULT_LOW:  rd_byte = i_prox_data[7:0];  // R10
      `SSS_ADDR_PROXIMITY_RESULT_HIGH: rd_byte = q.shadow[2];       // R10
      default:                         rd_byte = 8'h00;
    endcase
  end

  // next state: flags first, then the serial sequencer, then the byte load
  always_comb begin
    d       = q;
    ld      = 1'b0;
    d.scl_q = s_scl;
    d.sda_q = s_sda;
    // set beats clear so an event in the clear cycle is kept
    d.prox_irq    = i_prox_irq_set | (q.prox_irq & ~i_prox_irq_clr);  // R15
    d.light_irq   = i_ch0_irq_set | (q.light_irq & ~i_light_irq_clr); // R14 R15
    d.prox_ready  = q.prox_ready | i_prox_done;                       // R6
    d.light_ready = q.light_ready | i_light_done;                     // R7
    d.irq         = d.prox_irq | d.light_irq;                         // R15
    if (stop_seen) begin
      d.state = sss_pkg::SSS_IDLE;
      d.oe    = 1'b0;
    end else if (start_seen) begin
      d.state = sss_pkg::SSS_ADDR;
      d.cnt   = 4'h0;
      d.oe    = 1'b0;
    end else begin
      unique case (q.state)
        sss_pkg::SSS_IDLE: begin
          d.oe = 1'b0;
        end
        sss_pkg::SSS_ADDR, sss_pkg::SSS_CMD, sss_pkg::SSS_WDATA: begin
          if (scl_rise && q.cnt != `SSS_BITS_PER_BYTE) begin
            d.sh  = {q.sh[6:0], s_sda};
            d.cnt = q.cnt + 4'h1;
          end else if (scl_fall && q.cnt == `SSS_BITS_PER_BYTE) begin
            d.oe    = 1'b1;
            d.state = sss_pkg::SSS_ACK_BYTE;
            if (q.state == sss_pkg::SSS_ADDR) begin
              d.rw    = q.sh[0];
              d.state = sss_pkg::SSS_ACK_ADDR;
              if (q.sh[7:1] != SLAVE_ADDR) begin
                d.oe    = 1'b0;
                d.state = sss_pkg::SSS_IDLE;
              end
            end else if (q.state == sss_pkg::SSS_CMD) begin
              d.ptr     = q.sh[`SSS_CMD_ADDR_MSB:0];
              d.autoinc = q.sh[`SSS_CMD_TYPE_MSB:`SSS_CMD_TYPE_LSB] == `SSS_CMD_TYPE_AUTO_INC;
            end else if (q.autoinc) begin
              // written byte acknowledged and dropped: every byte here is read-only
              d.ptr = q.ptr + `SSS_ADDR_STEP;  // R3
            end
          end
        end
        sss_pkg::SSS_ACK_ADDR: begin
          if (scl_fall) begin
            d.cnt = 4'h0;
            d.oe  = 1'b0;
            if (q.rw) begin
              ld = 1'b1;
            end else begin
              d.state = sss_pkg::SSS_CMD;
            end
          end
        end
        sss_pkg::SSS_ACK_BYTE: begin
          if (scl_fall) begin
            d.oe    = 1'b0;
            d.cnt   = 4'h0;
            d.state = sss_pkg::SSS_WDATA;
          end
        end
        sss_pkg::SSS_RDATA: begin
          if (scl_fall) begin
            if (q.cnt == `SSS_BITS_PER_BYTE) begin
              d.oe    = 1'b0;
              d.state = sss_pkg::SSS_RACK;
            end else begin
              d.oe  = ~q.tx[`SSS_BYTE_MSB - 1];
              d.tx  = {q.tx[6:0], 1'b0};
              d.cnt = q.cnt + 4'h1;
            end
          end
        end
        sss_pkg::SSS_RACK: begin
          if (scl_rise) begin
            d.acked = ~s_sda;
          end else if (scl_fall) begin
            if (q.acked) begin
              ld = 1'b1;
            end else begin
              d.state = sss_pkg::SSS_IDLE;
            end
          end
        end
      endcase
    end
    // byte load: msb goes out at once; low-byte reads freeze their high byte
    if (ld) begin
      d.state = sss_pkg::SSS_RDATA;
      d.tx    = rd_byte;
      d.oe    = ~rd_byte[`SSS_BYTE_MSB];
      d.cnt   = `SSS_BIT_FIRST_SENT;
      for (int i = 0; i < `SSS_RESULT_COUNT; i++) begin
        if (q.ptr == `SSS_ADDR_LIGHT_CH0_LOW + 5'(2 * i)) begin
          d.shadow[i] = live_high[i];  // R11 R12
        end
      end
      if (q.autoinc) begin
        d.ptr = q.ptr + `SSS_ADDR_STEP;
      end
    end
  end

  // one register stage for the whole core state
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      q       <= sss_pkg::sss_core_t'('0);
      q.scl_q <= 1'b1;  // idle bus level, so release shows no false edge
      q.sda_q <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // open drain: the pin only ever pulls low
  assign o_sda        = 1'b0;
  assign o_sda_oe     = q.oe;
  assign o_sensor_irq = q.irq;

  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rst_n);

  sequence low0_read_s;
    ld && q.ptr == `SSS_ADDR_LIGHT_CH0_LOW;
  endsequence

  sequence high0_read_s;
    ld && q.ptr == `SSS_ADDR_LIGHT_CH0_HIGH;
  endsequence

  chk_step_code_const: assert property (  // R1
    ld && q.ptr == `SSS_ADDR_SILICON_STEP_CODE |=> q.tx == STEP_CODE)
    else $error("step code register does not read its fixed value");

  chk_part_code_const: assert property (  // R2
    ld && q.ptr == `SSS_ADDR_PART_CODE |=> q.tx == PART_CODE)
    else $error("part code not loaded for transmission");

  chk_status_write_ignored: assert property (  // R3
    q.state == sss_pkg::SSS_WDATA && !i_prox_irq_set && !i_ch0_irq_set && !i_prox_irq_clr
      && !i_light_irq_clr && !i_prox_done && !i_light_done |=> $stable(status_byte))
    else $error("status flags moved during a host write");

  chk_prox_irq_status: assert property (  // R4
    i_prox_irq_set |=> status_byte[`SSS_ST_PROXIMITY_IRQ_FLAG] && o_sensor_irq)
    else $error("proximity interrupt not shown in status");

  chk_light_irq_status: assert property (  // R5
    i_ch0_irq_set |=> status_byte[`SSS_ST_LIGHT_IRQ_FLAG] && o_sensor_irq)
    else $error("light interrupt not shown in status");

  chk_prox_ready_set: assert property (  // R6
    i_prox_done |=> status_byte[`SSS_ST_PROXIMITY_RESULT_READY]
      ##1 status_byte[`SSS_ST_PROXIMITY_RESULT_READY])
    else $error("proximity ready flag did not set and hold");

  chk_light_ready_set: assert property (  // R7
    i_light_done |=> status_byte[`SSS_ST_LIGHT_RESULT_READY]
      ##1 status_byte[`SSS_ST_LIGHT_RESULT_READY])
    else $error("light ready flag did not set and hold");

  chk_low_byte_map: assert property (  // R10
    ld && q.ptr == `SSS_ADDR_PROXIMITY_RESULT_LOW |=> q.tx == $past(i_prox_data[7:0]))
    else $error("proximity low byte mapped wrongly");

  chk_shadow_capture: assert property (  // R11
    low0_read_s |=> q.shadow[0] == $past(i_ch0_data[15:8]))
    else $error("shadow did not capture the high byte");

  chk_shadow_holds: assert property (  // R12
    !(ld && q.ptr == `SSS_ADDR_LIGHT_CH0_LOW) |=> $stable(q.shadow[0]))
    else $error("shadow changed without a low byte read");

  chk_high_from_shadow: assert property (  // R11 R12
    high0_read_s |=> q.tx == $past(q.shadow[0]))
    else $error("high byte not taken from the shadow");

  chk_light_irq_source: assert property (  // R14
    $rose(q.light_irq) |-> $past(i_ch0_irq_set))
    else $error("light interrupt raised without a channel 0 event");

  chk_irq_clear_release: assert property (  // R15
    q.prox_irq && !q.light_irq && i_prox_irq_clr && !i_prox_irq_set && !i_ch0_irq_set
      |=> !o_sensor_irq)
    else $error("interrupt output not released by clear");

  chk_irq_sticky: assert property (  // R15
    q.light_irq && !i_light_irq_clr |=> q.light_irq && o_sensor_irq)
    else $error("light interrupt flag dropped without a clear");

endmodule : sss_readout

/* File: test/sss_host_model.sv */
`timescale 1ns/1ps
// host side of the serial bus; the clock line stands high between frames
module sss_host_model (
  output logic      o_scl,
  output logic      o_sda,
  input  wire logic i_sda
);
  // bus idles released, pull-up gives high
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end

  // 80 ns clock; edges land on core falling edges, so the filter keeps their order
  task automatic bit_io(input logic b, output logic r);
    #16 o_sda = b;
    #24 o_scl = 1'b1;
    #24 r = i_sda;
    #16 o_scl = 1'b0;
  endtask : bit_io

  // start, or repeated start when the clock is low
  task automatic start;
    #16 o_sda = 1'b1;
    #64 o_scl = 1'b1;
    #80 o_sda = 1'b0;
    #80 o_scl = 1'b0;
  endtask : start

  // stop leaves both lines released
  task automatic stop;
    #16 o_sda = 1'b0;
    #64 o_scl = 1'b1;
    #80 o_sda = 1'b1;
    #80;
  endtask : stop

  // byte out, most significant first, then the device's ack
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask : wr_byte

  // byte in; ack keeps the word in one read, nack on the last byte
  task automatic rd_byte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(last, r);
  endtask : rd_byte
endmodule : sss_host_model

/* File: test/tb_sensor_status_data_readout.sv */
`timescale 1ns/1ps
module tb_sensor_status_data_readout;
  localparam logic [6:0] ADDR = 7'h39;
  localparam logic [7:0] STEP = 8'hC3;  // arbitrary value
  localparam logic [7:0] PART = 8'h3C;  // arbitrary value
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [15:0] res [3];
  logic [5:0]  flags = 6'h00;  // done l/p, set l/p, clear l/p
  logic        sda_oe;
  logic        irq;
  logic        ack;
  logic [15:0] v;
  logic [15:0] exp;
  wire         scl;
  wire         host_sda;
  wire         bus_sda;
  wire         dev_sda;
  int          mismatches = 0;
  int          total_checks = 0;
  int          seed = 32'h555f;
  int          st = 0;
  int          idx;

  // open drain: device pulls low, else host level over pull-up
  assign bus_sda = sda_oe ? dev_sda : host_sda;

  sss_host_model host (.o_scl(scl), .o_sda(host_sda), .i_sda(bus_sda));

  sss_readout #(.SLAVE_ADDR(ADDR), .STEP_CODE(STEP), .PART_CODE(PART)) DUT (
    .i_core_clk      (clk),
    .i_rst_n         (rst_n),
    .i_scl           (scl),
    .i_sda           (bus_sda),
    .o_sda           (dev_sda),
    .o_sda_oe        (sda_oe),
    .i_ch0_data      (res[0]),
    .i_ch1_data      (res[1]),
    .i_prox_data     (res[2]),
    .i_light_done    (flags[5]),
    .i_prox_done     (flags[4]),
    .i_ch0_irq_set   (flags[3]),
    .i_prox_irq_set  (flags[2]),
    .i_light_irq_clr (flags[1]),
    .i_prox_irq_clr  (flags[0]),
    .o_sensor_irq    (irq)
  );

  // core clock, 8 ns
  always #4 clk = ~clk;

  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    total_checks++;
    if (seen !== want) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, want);
    end
  endtask : check

  task automatic end_sim;
    $display("checks=%0d mismatches=%0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_sim

  // live results change on a falling edge, as measurement logic would
  task automatic new_data;
    @(negedge clk);
    for (int i = 0; i < 3; i++) res[i] = 16'($random(seed));
  endtask : new_data

  // one-cycle event pulses; the model lets a set win over a clear
  task automatic pulse(input logic [5:0] f);
    @(negedge clk) flags = f;
    @(negedge clk) flags = 6'h00;
    if (f[5]) st |= 1;
    if (f[4]) st |= 2;
    if (f[3]) st |= 16;
    if (f[2]) st |= 32;
    if (f[1] && !f[3]) st &= ~16;
    if (f[0] && !f[2]) st &= ~32;
    check({15'h0000, irq}, 16'((st & 48) != 0));
  endtask : pulse

  // command write, repeated start, one or two bytes back; chg moves live data mid-word
  task automatic rd(input logic [4:0] a, input logic word, input logic chg,
                    output logic [15:0] d);
    logic ok;
    d = 16'h0000;
    host.start();
    host.wr_byte({ADDR, 1'b0}, ok);
    host.wr_byte(word ? {3'b101, a} : {3'b000, a}, ack);
    ok &= ack;
    host.start();
    host.wr_byte({ADDR, 1'b1}, ack);
    ok &= ack;
    host.rd_byte(~word, d[7:0]);
    if (chg) new_data();
    if (word) host.rd_byte(1'b1, d[15:8]);
    host.stop();
    check({15'h0000, ok}, 16'h0001);
  endtask : rd

  // main sequence
  initial begin
    for (int i = 0; i < 3; i++) res[i] = 16'h0000;
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    repeat (6) @(negedge clk);
    rd(5'h11, 1'b0, 1'b0, v);
    check(v, {8'h00, STEP});
    rd(5'h12, 1'b0, 1'b0, v);
    check(v, {8'h00, PART});
    rd(5'h1F, 1'b0, 1'b0, v);
    check(v, 16'h0000);
    host.start();
    host.wr_byte({ADDR ^ 7'h01, 1'b0}, ack);
    host.stop();
    check({15'h0000, ack}, 16'h0000);
    $display("test identity done");
    rd(5'h13, 1'b0, 1'b0, v);
    check(v, 16'(st));
    pulse(6'b100000);
    rd(5'h13, 1'b0, 1'b0, v);
    check(v, 16'(st));
    pulse(6'b010000);
    rd(5'h13, 1'b0, 1'b0, v);
    check(v, 16'(st));
    pulse(6'b001000);
    rd(5'h13, 1'b0, 1'b0, v);
    check(v, 16'(st));
    pulse(6'b000100);
    rd(5'h13, 1'b0, 1'b0, v);
    check(v, 16'(st));
    // writes to the status byte carry zeros in reserved bits and must not land
    host.start();
    host.wr_byte({ADDR, 1'b0}, ack);
    host.wr_byte(8'h13, ack);
    host.wr_byte(8'h00, ack);
    host.stop();
    rd(5'h13, 1'b0, 1'b0, v);
    check(v, 16'(st));
    pulse(6'b000010);
    rd(5'h13, 1'b0, 1'b0, v);
    check(v, 16'(st));
    pulse(6'b000001);
    pulse(6'b001010);
    pulse(6'b000011);
    rd(5'h13, 1'b0, 1'b0, v);
    check(v, 16'(st));
    $display("test status done");
    // word reads of every result with fresh integrations between the two bytes
    for (int k = 0; k < 6; k++) begin
      idx = k % 3;
      new_data();
      exp = res[idx];
      rd(5'h14 + 5'(2 * idx), 1'b1, 1'b1, v);
      check(v, exp);
    end
    $display("test results done");
    end_sim();
  end

  // watchdog, well beyond the expected 70 us of traffic
  initial begin
    #400000;
    mismatches++;
    $display("watchdog expired");
    end_sim();
  end
endmodule : tb_sensor_status_data_readout
